// ---- rtl/adc_result_pkg.sv ----
// package: register map, field layout, encodings and state of the result bank
package adc_result_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int RES_W  = 10;
  localparam int WORD_W = 16;

  // byte addresses, one aligned word per register
  localparam logic [7:0] OFF_COMP_CTRL = 8'h00;
  localparam logic [7:0] OFF_THR_CTRL  = 8'h04;
  localparam logic [7:0] OFF_FORMAT    = 8'h08;
  localparam logic [7:0] OFF_REPEAT    = 8'h0C;
  localparam logic [7:0] OFF_COUNT     = 8'h10;
  localparam logic [7:0] OFF_FLT_H     = 8'h14;
  localparam logic [7:0] OFF_FLT_L     = 8'h18;
  localparam logic [7:0] OFF_RES_H     = 8'h1C;
  localparam logic [7:0] OFF_RES_L     = 8'h20;
  localparam logic [7:0] OFF_PREV_H    = 8'h24;
  localparam logic [7:0] OFF_PREV_L    = 8'h28;
  localparam logic [7:0] OFF_ACC_H     = 8'h2C;
  localparam logic [7:0] OFF_ACC_L     = 8'h30;
  localparam logic [7:0] OFF_STPT_H    = 8'h34;
  localparam logic [7:0] OFF_STPT_L    = 8'h38;
  localparam logic [7:0] OFF_ERR_H     = 8'h3C;
  localparam logic [7:0] OFF_ERR_L     = 8'h40;
  localparam logic [7:0] OFF_LTH_H     = 8'h44;
  localparam logic [7:0] OFF_LTH_L     = 8'h48;
  localparam logic [7:0] OFF_UTH_H     = 8'h4C;
  localparam logic [7:0] OFF_UTH_L     = 8'h50;
  localparam logic [7:0] OFF_STATUS    = 8'h54;
  localparam logic [7:0] OFF_IRQ_STAT  = 8'h58;
  localparam logic [7:0] OFF_IRQ_MASK  = 8'h5C;

  // computation_control fields
  localparam int CC_PREV_SEL  = 7;
  localparam int CC_SHIFT_LSB = 4;
  localparam int CC_CLEAR     = 3;
  localparam int CC_MODE_LSB  = 0;
  // threshold_control fields
  localparam int TC_CALC_LSB  = 4;
  localparam int TC_TMD_LSB   = 0;
  // format, status and interrupt bits
  localparam int FMT_BIT      = 0;
  localparam int ST_BELOW     = 0;
  localparam int ST_ABOVE     = 1;
  localparam int IRQ_DONE     = 0;
  localparam int IRQ_THR      = 1;
  localparam int IRQ_W        = 2;

  localparam logic [7:0] COUNT_MAX = 8'hFF;

  // computation modes
  localparam logic [2:0] MODE_BASIC   = 3'h0;
  localparam logic [2:0] MODE_ACCUM   = 3'h1;
  localparam logic [2:0] MODE_AVERAGE = 3'h2;
  localparam logic [2:0] MODE_BURST   = 3'h3;
  localparam logic [2:0] MODE_LPF     = 3'h4;

  // calculation select
  localparam logic [2:0] CALC_RES_PREV  = 3'h0;
  localparam logic [2:0] CALC_RES_STPT  = 3'h1;
  localparam logic [2:0] CALC_FLT_PREV  = 3'h2;
  localparam logic [2:0] CALC_FLT_STPT  = 3'h3;
  localparam logic [2:0] CALC_STPT_FLT  = 3'h4;

  // threshold interrupt modes
  localparam logic [2:0] TMD_NEVER   = 3'h0;
  localparam logic [2:0] TMD_BELOW   = 3'h1;
  localparam logic [2:0] TMD_NOT_LOW = 3'h2;
  localparam logic [2:0] TMD_INSIDE  = 3'h3;
  localparam logic [2:0] TMD_OUTSIDE = 3'h4;
  localparam logic [2:0] TMD_NOT_UP  = 3'h5;
  localparam logic [2:0] TMD_ABOVE   = 3'h6;
  localparam logic [2:0] TMD_ALWAYS  = 3'h7;

  typedef struct packed {
    logic              prev_sel;
    logic [2:0]        shift;
    logic [2:0]        mode;
    logic [2:0]        calc_sel;
    logic [2:0]        thr_mode;
    logic              fmt;
    logic [7:0]        repeat_thr;
    logic [7:0]        count;
    logic              restart;
    logic [RES_W-1:0]  result;
    logic [WORD_W-1:0] prev;
    logic [WORD_W-1:0] acc;
    logic [WORD_W-1:0] filter;
    logic [WORD_W-1:0] setpoint;
    logic [WORD_W-1:0] err;
    logic [WORD_W-1:0] lower;
    logic [WORD_W-1:0] upper;
    logic              below;
    logic              above;
    logic [IRQ_W-1:0]  irq_stat;
    logic [IRQ_W-1:0]  irq_mask;
    logic [DATA_W-1:0] rdata;
    logic              slverr;
  } state_type;

  localparam state_type RESET_STATE = '0;

endpackage

// ---- rtl/calc_if.sv ----
// interface: operands and results between the register bank and the calculator
`timescale 1ns/1ps
`default_nettype none
interface calc_if;
  import adc_result_pkg::*;
  logic [2:0]        mode;
  logic [2:0]        shift;
  logic [2:0]        calc_sel;
  logic [2:0]        thr_mode;
  logic [RES_W-1:0]  result;
  logic [WORD_W-1:0] prev;
  logic [WORD_W-1:0] acc;
  logic [WORD_W-1:0] filter;
  logic [WORD_W-1:0] setpoint;
  logic [WORD_W-1:0] lower;
  logic [WORD_W-1:0] upper;
  logic [WORD_W-1:0] acc_sum;
  logic [WORD_W-1:0] lpf_out;
  logic [WORD_W-1:0] shifted;
  logic [WORD_W-1:0] err;
  logic              below;
  logic              above;
  logic              thr_hit;
  modport regs (output mode, shift, calc_sel, thr_mode, result, prev, acc,
                output filter, setpoint, lower, upper,
                input acc_sum, lpf_out, shifted, err, below, above, thr_hit);
  modport calc (input mode, shift, calc_sel, thr_mode, result, prev, acc,
                input filter, setpoint, lower, upper,
                output acc_sum, lpf_out, shifted, err, below, above, thr_hit);
endinterface
`default_nettype wire

// ---- rtl/adc_calc.sv ----
// calculator: accumulate, filter, error and threshold comparison
`timescale 1ns/1ps
`default_nettype none
module adc_calc (
  // operands in, results out
  calc_if.calc c
);
  import adc_result_pkg::*;

  logic signed [WORD_W-1:0] res_s;
  logic signed [WORD_W-1:0] diff_s;
  logic signed [WORD_W-1:0] step_s;
  logic signed [WORD_W-1:0] shift_s;
  logic signed [WORD_W-1:0] err_s;

  always_comb begin
    res_s     = signed'({{(WORD_W-RES_W){1'b0}}, c.result});
    c.acc_sum = c.acc + res_s;
    shift_s   = signed'(c.acc) >>> c.shift;
    c.shifted = shift_s; // [RULE1]
    // first-order low-pass: move a 1/2^shift step toward the new sample
    diff_s    = res_s - signed'(c.filter);
    step_s    = diff_s >>> c.shift;
    c.lpf_out = c.filter + step_s; // [RULE2]
    case (c.calc_sel)
      CALC_RES_PREV: err_s = res_s - signed'(c.prev);
      CALC_RES_STPT: err_s = res_s - signed'(c.setpoint); // [RULE10]
      CALC_FLT_PREV: err_s = signed'(c.filter) - signed'(c.prev);
      CALC_FLT_STPT: err_s = signed'(c.filter) - signed'(c.setpoint);
      CALC_STPT_FLT: err_s = signed'(c.setpoint) - signed'(c.filter);
      // reserved codes fall back to result against setpoint
      default:       err_s = res_s - signed'(c.setpoint);
    endcase
    c.err   = err_s; // [RULE11]
    c.below = err_s < signed'(c.lower); // [RULE12]
    c.above = err_s > signed'(c.upper); // [RULE12]
    unique case (c.thr_mode)
      TMD_NEVER:   c.thr_hit = 1'b0;
      TMD_BELOW:   c.thr_hit = c.below;
      TMD_NOT_LOW: c.thr_hit = ~c.below;
      TMD_INSIDE:  c.thr_hit = ~c.below & ~c.above;
      TMD_OUTSIDE: c.thr_hit = c.below | c.above;
      TMD_NOT_UP:  c.thr_hit = ~c.above;
      TMD_ABOVE:   c.thr_hit = c.above;
      TMD_ALWAYS:  c.thr_hit = 1'b1;
    endcase
  end

endmodule
`default_nettype wire

// ---- rtl/adc_result_regs.sv ----
// result register bank of the adc computation extension, apb slave
//
// Notes on behaviour
// RULE1: in accumulate, average and burst modes the filter output is the accumulator shifted right by the shift count.
// RULE2: in low-pass mode the filter output holds the low-pass filter result instead of the shifted accumulator.
// RULE3: with format bit 0 the result is left-justified, bits 9..2 high and bits 1..0 in low byte bits 7..6.
// RULE4: with format bit 1 the result is right-justified, bits 9..8 in high byte bits 1..0 and bits 7..0 low.
// RULE5: software must not use the six unused result bits of either format; they read as zero here.
// RULE6: with previous-source select 1 the filter output is captured into previous-value at conversion start.
// RULE7: with previous-source select 0 the conversion result is captured into previous-value at conversion start.
// RULE8: a captured conversion result is justified in previous-value the same way as the live result.
// RULE9: a 16-bit software-writable signed accumulator is kept, its top bit being the sign.
// RULE10: a 16-bit software-writable setpoint serves as operand of the error calculation.
// RULE11: a 16-bit read-only calculation error is computed with the formula picked by calculation select.
// RULE12: the error is compared with lower and upper thresholds, setting two flags and an interrupt by mode.
// RULE13: the conversion counter counts triggers and saturates at its maximum instead of wrapping.
//
// Implementation choices: the register addresses and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module adc_result_regs (
  // apb clock and reset
  input  wire logic                                pclk,
  input  wire logic                                presetn,
  // apb slave
  input  wire logic                                psel,
  input  wire logic                                penable,
  input  wire logic                                pwrite,
  input  wire logic [adc_result_pkg::ADDR_W-1:0]   paddr,
  input  wire logic [adc_result_pkg::DATA_W-1:0]   pwdata,
  output logic      [adc_result_pkg::DATA_W-1:0]   prdata,
  output logic                                     pready,
  output logic                                     pslverr,
  // converter events, same clock
  input  wire logic                                conv_trigger,
  input  wire logic                                conv_start,
  input  wire logic                                conv_done,
  input  wire logic [adc_result_pkg::RES_W-1:0]    conv_data,
  // interrupt
  output logic                                     irq
);
  import adc_result_pkg::*;

  state_type  st;
  state_type  next_st;
  logic       setup;
  logic       wr;
  logic       rd;
  logic [7:0] waddr;
  logic [8:0] rbyte;
  logic       test;

  calc_if cif ();

  adc_calc u_calc (
    .c (cif.calc)
  );

  assign cif.mode     = st.mode;
  assign cif.shift    = st.shift;
  assign cif.calc_sel = st.calc_sel;
  assign cif.thr_mode = st.thr_mode;
  // a finishing conversion feeds its own sample straight into the math
  assign cif.result   = conv_done ? conv_data : st.result;
  assign cif.prev     = st.prev;
  assign cif.acc      = st.acc;
  assign cif.filter   = st.filter;
  assign cif.setpoint = st.setpoint;
  assign cif.lower    = st.lower;
  assign cif.upper    = st.upper;

  function automatic logic [7:0] res_high(input logic fmt,
                                          input logic [RES_W-1:0] r);
    res_high = fmt ? {6'h00, r[9:8]} : r[9:2]; // [RULE3] [RULE4] [RULE5]
  endfunction

  function automatic logic [7:0] res_low(input logic fmt,
                                         input logic [RES_W-1:0] r);
    res_low = fmt ? r[7:0] : {r[1:0], 6'h00}; // [RULE3] [RULE4] [RULE5]
  endfunction

  // bit 8 flags a mapped address, bits 7..0 the byte that reads back
  function automatic logic [8:0] read_byte(input logic [7:0] a,
                                           input state_type s);
    logic [7:0] b;
    logic       hit;
    b   = 8'h00;
    hit = 1'b1;
    case (a)
      OFF_COMP_CTRL: b = {s.prev_sel, s.shift, 1'b0, 1'b0, s.mode[1:0]} |
                         {5'h00, s.mode};
      OFF_THR_CTRL:  b = {1'b0, s.calc_sel, 1'b0, s.thr_mode};
      OFF_FORMAT:    b = {7'h00, s.fmt};
      OFF_REPEAT:    b = s.repeat_thr;
      OFF_COUNT:     b = s.count;
      OFF_FLT_H:     b = s.filter[15:8];
      OFF_FLT_L:     b = s.filter[7:0];
      OFF_RES_H:     b = res_high(s.fmt, s.result);
      OFF_RES_L:     b = res_low(s.fmt, s.result);
      OFF_PREV_H:    b = s.prev[15:8];
      OFF_PREV_L:    b = s.prev[7:0];
      OFF_ACC_H:     b = s.acc[15:8];
      OFF_ACC_L:     b = s.acc[7:0];
      OFF_STPT_H:    b = s.setpoint[15:8];
      OFF_STPT_L:    b = s.setpoint[7:0];
      OFF_ERR_H:     b = s.err[15:8];
      OFF_ERR_L:     b = s.err[7:0];
      OFF_LTH_H:     b = s.lower[15:8];
      OFF_LTH_L:     b = s.lower[7:0];
      OFF_UTH_H:     b = s.upper[15:8];
      OFF_UTH_L:     b = s.upper[7:0];
      OFF_STATUS:    b = {6'h00, s.above, s.below};
      OFF_IRQ_STAT:  b = {6'h00, s.irq_stat};
      OFF_IRQ_MASK:  b = {6'h00, s.irq_mask};
      default:       hit = 1'b0;
    endcase
    read_byte = {hit, b};
  endfunction

  always_comb begin
    next_st = st;
    setup   = psel & ~penable;
    wr      = psel & penable & pwrite;
    rd      = psel & penable & ~pwrite;
    waddr   = {paddr[7:2], 2'b00};
    rbyte   = read_byte(waddr, st);
    test    = 1'b0;

    // outside low-pass mode the filter tracks the shifted accumulator
    if (st.mode != MODE_LPF) begin
      next_st.filter = cif.shifted; // [RULE1]
    end

    // read data and error are latched in setup so the answer comes from
    // flops; values that move during the access phase are not seen
    if (setup) begin
      next_st.rdata  = {24'h000000, rbyte[7:0]};
      next_st.slverr = ~rbyte[8];
    end

    if (wr) begin
      case (waddr)
        OFF_COMP_CTRL: begin
          next_st.prev_sel = pwdata[CC_PREV_SEL];
          next_st.shift    = pwdata[CC_SHIFT_LSB +: 3];
          next_st.mode     = pwdata[CC_MODE_LSB +: 3];
          // clear strobe is self-clearing and reads back as zero
          if (pwdata[CC_CLEAR]) begin
            next_st.acc     = '0;
            next_st.count   = '0;
            next_st.restart = 1'b0;
          end
        end
        OFF_THR_CTRL: begin
          next_st.calc_sel = pwdata[TC_CALC_LSB +: 3];
          next_st.thr_mode = pwdata[TC_TMD_LSB +: 3];
        end
        OFF_FORMAT: next_st.fmt        = pwdata[FMT_BIT];
        OFF_REPEAT: next_st.repeat_thr = pwdata[7:0];
        OFF_COUNT:  next_st.count      = pwdata[7:0];
        OFF_RES_H: begin
          if (st.fmt) begin
            next_st.result[9:8] = pwdata[1:0]; // [RULE4]
          end else begin
            next_st.result[9:2] = pwdata[7:0]; // [RULE3]
          end
        end
        OFF_RES_L: begin
          if (st.fmt) begin
            next_st.result[7:0] = pwdata[7:0]; // [RULE4]
          end else begin
            next_st.result[1:0] = pwdata[7:6]; // [RULE3]
          end
        end
        OFF_ACC_H:  next_st.acc[15:8]      = pwdata[7:0]; // [RULE9]
        OFF_ACC_L:  next_st.acc[7:0]       = pwdata[7:0]; // [RULE9]
        OFF_STPT_H: next_st.setpoint[15:8] = pwdata[7:0]; // [RULE10]
        OFF_STPT_L: next_st.setpoint[7:0]  = pwdata[7:0]; // [RULE10]
        OFF_LTH_H:  next_st.lower[15:8]    = pwdata[7:0];
        OFF_LTH_L:  next_st.lower[7:0]     = pwdata[7:0];
        OFF_UTH_H:  next_st.upper[15:8]    = pwdata[7:0];
        OFF_UTH_L:  next_st.upper[7:0]     = pwdata[7:0];
        OFF_IRQ_MASK: next_st.irq_mask     = pwdata[IRQ_W-1:0];
        // read-only and unmapped words ignore writes
        default: ;
      endcase
    end

    // read-to-clear drops only the bits that were actually returned,
    // so an event landing after the setup sample is kept
    if (rd && waddr == OFF_IRQ_STAT) begin
      next_st.irq_stat = st.irq_stat & ~st.rdata[IRQ_W-1:0];
    end

    // hardware counting wins over a software write in the same cycle
    if (conv_trigger && st.count != COUNT_MAX) begin
      next_st.count = st.count + 8'h01; // [RULE13]
    end

    if (conv_start) begin
      if (st.prev_sel) begin
        next_st.prev = st.filter; // [RULE6]
      end else begin
        next_st.prev = {res_high(st.fmt, st.result),
                        res_low(st.fmt, st.result)}; // [RULE7] [RULE8]
      end
    end

    if (conv_done) begin
      next_st.result             = conv_data;
      next_st.irq_stat[IRQ_DONE] = 1'b1;
      next_st.restart            = 1'b0;
      case (st.mode)
        MODE_ACCUM, MODE_AVERAGE, MODE_BURST: begin
          next_st.acc = st.restart ? 16'(conv_data) : cif.acc_sum; // [RULE9]
        end
        MODE_LPF: begin
          next_st.acc    = cif.acc_sum;
          next_st.filter = cif.lpf_out; // [RULE2]
        end
        default: ;
      endcase
      // average, burst and low-pass modes test only once enough triggers have been seen
      if (st.mode == MODE_AVERAGE || st.mode == MODE_BURST ||
          st.mode == MODE_LPF) begin
        test = st.count >= st.repeat_thr; // [RULE13]
      end else begin
        test = 1'b1;
      end
      if (test) begin
        next_st.err   = cif.err; // [RULE11]
        next_st.below = cif.below; // [RULE12]
        next_st.above = cif.above; // [RULE12]
        if (cif.thr_hit) begin
          next_st.irq_stat[IRQ_THR] = 1'b1; // [RULE12]
        end
        // an average window closes: restart the sum on the next sample
        if (st.mode == MODE_AVERAGE || st.mode == MODE_BURST) begin
          next_st.count   = '0;
          next_st.restart = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= RESET_STATE;
    end else begin
      st <= next_st;
    end
  end

  assign prdata  = st.rdata;
  assign pready  = 1'b1;
  assign pslverr = st.slverr;
  assign irq     = |(st.irq_stat & st.irq_mask);

endmodule
`default_nettype wire

// ---- dv/adc_result_regs_chk.sv ----
// checker: bus and interrupt relations at the result bank's ports
`timescale 1ns/1ps
`default_nettype none
module adc_result_regs_chk (
  // apb
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // converter and interrupt
  input wire logic        conv_trigger,
  input wire logic        conv_start,
  input wire logic        conv_done,
  input wire logic [9:0]  conv_data,
  input wire logic        irq
);
  import adc_result_pkg::*;
  logic       acc_edge;
  logic       mask_wr;
  logic       stat_rd;
  logic [1:0] mask_sh;
  logic       fmt_sh;
  assign acc_edge = psel && penable && pready;
  assign mask_wr  = acc_edge && pwrite && paddr[7:2] == OFF_IRQ_MASK[7:2];
  assign stat_rd  = acc_edge && !pwrite && paddr[7:2] == OFF_IRQ_STAT[7:2];
  // shadows of the mask and format bits, updated at the same edge as the bank
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_sh <= 2'b00;
      fmt_sh  <= 1'b0;
    end else if (acc_edge && pwrite) begin
      if (paddr[7:2] == OFF_IRQ_MASK[7:2]) mask_sh <= pwdata[1:0];
      if (paddr[7:2] == OFF_FORMAT[7:2]) fmt_sh <= pwdata[0];
    end
  end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  a_ready_always: assert property (pready)
    else $error("pready low");
  a_prdata_narrow: assert property (prdata[31:8] == 24'h0)
    else $error("prdata upper bits set");
  a_slverr_decode: assert property (psel && !penable |=>
    pslverr == ($past(paddr) > 8'h5F)) else $error("pslverr decode wrong");
  a_unmapped_zero: assert property (acc_edge && pslverr |-> prdata == 32'h0)
    else $error("unmapped read data not zero");
  a_rdata_holds: assert property (!(psel && !penable) |=>
    $stable(prdata) && $stable(pslverr)) else $error("read data moved");
  a_masked_quiet: assert property (mask_sh == 2'b00 |-> !irq)
    else $error("irq high while masked");
  a_done_raises: assert property (conv_done && mask_sh[0] && !mask_wr |=> irq)
    else $error("irq missing after done");
  a_irq_rise_cause: assert property ($rose(irq) |->
    $past(conv_done) || $past(mask_wr)) else $error("irq rose unprompted");
  a_irq_fall_cause: assert property ($fell(irq) |->
    $past(stat_rd) || $past(mask_wr)) else $error("irq fell unprompted");
  a_res_left_pad: assert property (acc_edge && !pwrite && !fmt_sh &&
    paddr[7:2] == OFF_RES_L[7:2] |-> prdata[5:0] == 6'h00)
    else $error("left format low pad set");
  a_res_right_pad: assert property (acc_edge && !pwrite && fmt_sh &&
    paddr[7:2] == OFF_RES_H[7:2] |-> prdata[7:2] == 6'h00)
    else $error("right format high pad set");
endmodule
bind adc_result_regs adc_result_regs_chk chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .conv_trigger(conv_trigger), .conv_start(conv_start),
  .conv_done(conv_done), .conv_data(conv_data), .irq(irq));
`default_nettype wire

// ---- dv/adc_result_regs_bench.sv ----
// testbench: apb master, converter pulses and reference model
`timescale 1ns/1ps
`default_nettype none
module adc_result_regs_bench;
  import adc_result_pkg::*;
  logic             pclk;
  logic             presetn;
  logic             psel;
  logic             penable;
  logic             pwrite;
  logic [7:0]       paddr;
  logic [31:0]      pwdata;
  wire logic [31:0] prdata;
  wire logic        pready;
  wire logic        pslverr;
  wire logic        irq;
  logic             conv_trigger;
  logic             conv_start;
  logic             conv_done;
  logic [9:0]       conv_data;
  int               errors;
  int               checks;
  logic [31:0]      seed;
  logic [31:0]      rdv;
  logic             erv;
  logic [15:0]      m_res, m_prev, m_acc, m_flt, m_stpt, m_err, m_low, m_up;
  logic [2:0]       m_mode, m_shift, m_calc, m_tmd;
  logic [7:0]       m_cnt, m_rpt;
  logic [1:0]       m_stat, m_mask;
  logic             m_fmt, m_psel, m_below, m_above;
  localparam logic [7:0] RO_ADDR [5] = '{OFF_FLT_H, OFF_PREV_L, OFF_ERR_H,
                                         OFF_ERR_L, OFF_STATUS};
  localparam logic [7:0] RW_ADDR [6] = '{OFF_ACC_H, OFF_ACC_L, OFF_STPT_H,
                                         OFF_STPT_L, OFF_LTH_H, OFF_UTH_L};

  adc_result_regs dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .conv_trigger(conv_trigger), .conv_start(conv_start),
    .conv_done(conv_done), .conv_data(conv_data), .irq(irq));

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic test_done;
    if (errors == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      n++;
      if (n > 50) begin
        errors++;
        test_done();
      end
      @(posedge pclk);
    end
    rdv = prdata;
    erv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rdv);
    chk("slverr", 32'h0, {31'h0, erv});
  endtask

  task automatic w16(input logic [7:0] a, input logic [15:0] v);
    apb(1'b1, a, {24'h0, v[15:8]});
    apb(1'b1, a + 8'h04, {24'h0, v[7:0]});
  endtask

  // outside low-pass mode the filter tracks the accumulator continuously
  task automatic upd_flt;
    if (m_mode != MODE_LPF) m_flt = $signed(m_acc) >>> m_shift;
  endtask

  task automatic cfg;
    apb(1'b1, OFF_COMP_CTRL, {24'h0, m_psel, m_shift, 1'b0, m_mode});
    apb(1'b1, OFF_THR_CTRL, {25'h0, m_calc, 1'b0, m_tmd});
    apb(1'b1, OFF_FORMAT, {31'h0, m_fmt});
    apb(1'b1, OFF_IRQ_MASK, {30'h0, m_mask});
    upd_flt();
  endtask

  task automatic pulse(input logic [2:0] p, input logic [9:0] d);
    @(posedge pclk);
    conv_trigger <= p[2];
    conv_start <= p[1];
    conv_done <= p[0];
    conv_data <= d;
    @(posedge pclk);
    conv_trigger <= 1'b0;
    conv_start <= 1'b0;
    conv_done <= 1'b0;
    conv_data <= ~d;
  endtask

  task automatic conv(input logic [9:0] d);
    logic [15:0]        r;
    logic [15:0]        e;
    logic signed [15:0] t;
    logic               hit;
    r = {6'h0, d};
    m_prev = m_psel ? m_flt : (m_fmt ? m_res : {m_res[9:0], 6'h0});
    pulse(3'b010, ~d);
    pulse(3'b001, d);
    case (m_calc)
      CALC_RES_PREV: e = r - m_prev;
      CALC_FLT_PREV: e = m_flt - m_prev;
      CALC_FLT_STPT: e = m_flt - m_stpt;
      CALC_STPT_FLT: e = m_stpt - m_flt;
      default:       e = r - m_stpt;
    endcase
    m_res = r;
    if (m_mode != MODE_BASIC && m_mode <= MODE_LPF) m_acc = m_acc + r;
    if (m_mode == MODE_LPF) begin
      t = $signed(r - m_flt) >>> m_shift;
      m_flt = m_flt + t;
    end
    upd_flt();
    if (m_mode <= MODE_ACCUM || m_mode > MODE_LPF || m_cnt >= m_rpt) begin
      m_err = e;
      m_below = $signed(e) < $signed(m_low);
      m_above = $signed(e) > $signed(m_up);
      case (m_tmd)
        TMD_NEVER:   hit = 1'b0;
        TMD_BELOW:   hit = m_below;
        TMD_NOT_LOW: hit = !m_below;
        TMD_INSIDE:  hit = !m_below && !m_above;
        TMD_OUTSIDE: hit = m_below || m_above;
        TMD_NOT_UP:  hit = !m_above;
        TMD_ABOVE:   hit = m_above;
        default:     hit = 1'b1;
      endcase
      m_stat[1] = m_stat[1] | hit;
    end
    m_stat[0] = 1'b1;
  endtask

  task automatic check_all(input logic ck);
    @(posedge pclk);
    #1;
    chk("irq", {31'h0, |(m_stat & m_mask)}, {31'h0, irq});
    rchk(OFF_RES_H, m_fmt ? {30'h0, m_res[9:8]} : {24'h0, m_res[9:2]},
         "res_h");
    rchk(OFF_RES_L, m_fmt ? {24'h0, m_res[7:0]} : {24'h0, m_res[1:0], 6'h0},
         "res_l");
    rchk(OFF_PREV_H, {24'h0, m_prev[15:8]}, "prev_h");
    rchk(OFF_PREV_L, {24'h0, m_prev[7:0]}, "prev_l");
    rchk(OFF_FLT_H, {24'h0, m_flt[15:8]}, "flt_h");
    rchk(OFF_FLT_L, {24'h0, m_flt[7:0]}, "flt_l");
    rchk(OFF_ACC_H, {24'h0, m_acc[15:8]}, "acc_h");
    rchk(OFF_ACC_L, {24'h0, m_acc[7:0]}, "acc_l");
    if (ck) begin
      rchk(OFF_ERR_H, {24'h0, m_err[15:8]}, "err_h");
      rchk(OFF_ERR_L, {24'h0, m_err[7:0]}, "err_l");
      rchk(OFF_STATUS, {30'h0, m_above, m_below}, "status");
    end
    rchk(OFF_IRQ_STAT, {30'h0, m_stat}, "irq_stat");
    m_stat = 2'b00;
    @(posedge pclk);
    #1;
    chk("irq_clr", 32'h0, {31'h0, irq});
  endtask

  initial begin
    errors = 0;
    checks = 0;
    seed = 32'hDE4020DA;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    conv_trigger = 1'b0;
    conv_start = 1'b0;
    conv_done = 1'b0;
    conv_data = 10'h000;
    {m_res, m_prev, m_acc, m_flt, m_stpt, m_err, m_low, m_up} = '0;
    {m_mode, m_shift, m_calc, m_tmd, m_cnt, m_rpt, m_stat, m_mask} = '0;
    {m_fmt, m_psel, m_below, m_above} = '0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    for (int a = 0; a < 8'h60; a += 4) rchk(a[7:0], 32'h0, "reset");
    apb(1'b1, 8'hFC, 32'hFF);
    apb(1'b0, 8'h60, 32'h0);
    chk("unmapped", 32'h1, {rdv[30:0], erv});
    // read-only words must ignore writes, before the accumulator moves
    foreach (RO_ADDR[i]) begin
      apb(1'b1, RO_ADDR[i], 32'hFF);
      rchk(RO_ADDR[i], 32'h0, "ro");
    end
    foreach (RW_ADDR[i]) begin
      seed = lfsr(seed);
      apb(1'b1, RW_ADDR[i], seed);
      rchk(RW_ADDR[i], {24'h0, seed[7:0]}, "rw");
    end
    apb(1'b1, OFF_COUNT, 32'hFC);
    repeat (2) pulse(3'b100, seed[9:0]);
    rchk(OFF_COUNT, 32'hFE, "count");
    repeat (3) pulse(3'b100, seed[9:0]);
    rchk(OFF_COUNT, 32'hFF, "count_sat");
    {m_stpt, m_low, m_up, m_acc} = {16'h0180, 16'hFF80, 16'h0080, 16'hFF00};
    w16(OFF_STPT_H, m_stpt);
    w16(OFF_LTH_H, m_low);
    w16(OFF_UTH_H, m_up);
    w16(OFF_ACC_H, m_acc);
    apb(1'b1, OFF_COUNT, 32'h0);
    m_rpt = 8'hFF;
    apb(1'b1, OFF_REPEAT, {24'h0, m_rpt});
    for (int i = 0; i < 40; i++) begin
      seed = lfsr(seed);
      {m_mask, m_shift, m_psel, m_fmt} = seed[6:0];
      {m_mode, m_calc, m_tmd} = {3'(i % 8), 3'(i / 5), 3'(i + i / 8)};
      cfg();
      conv(seed[17:8]);
      check_all(1'b1);
    end
    // sums below the repeat count never reach the threshold test
    for (int md = 2; md < 4; md++) begin
      m_mode = 3'(md);
      cfg();
      seed = lfsr(seed);
      conv(seed[9:0]);
      check_all(1'b0);
    end
    apb(1'b1, OFF_COMP_CTRL, 32'h08);
    {m_acc, m_flt} = '0;
    {m_mode, m_shift, m_rpt, m_mask} = {MODE_LPF, 3'h3, 8'h00, 2'b11};
    {m_calc, m_tmd} = {CALC_FLT_STPT, TMD_OUTSIDE};
    apb(1'b1, OFF_REPEAT, 32'h0);
    cfg();
    repeat (8) begin
      seed = lfsr(seed);
      conv(seed[9:0]);
      check_all(1'b1);
    end
    test_done();
  end
endmodule
`default_nettype wire
